// *** window_geom_regs.sv ***
// Register bank for first window geometry, scroll bounds and second window start.
// Assumes an AXI4-Lite master on aclk and fetch pulses from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
module window_geom_regs #(
    parameter int ADDR_W = 12
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              frame_start,
    input  wire logic              pix_req,
    output logic [19:0]            fetch_addr_r,
    output logic                   fetch_valid_r,
    output logic                   line_last_r,
    output logic                   frame_last_r,
    output logic [19:0]            second_start_r
);
    logic [15:0]       regs_r [window_geom_pkg::NUM_SLOTS];
    logic              aw_have_r;
    logic              w_have_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              awready_r;
    logic              wready_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              arready_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic [19:0]       second_r;

    window_cfg_if cfg_bus ();

    // Byte address to storage slot; shared by both bus directions
    function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] a);
        logic [11:0] idx;
        idx = {2'b00, a[ADDR_W-1:2]};
        if (a[1:0] != 2'b00)
            slot_of = window_geom_pkg::S_NONE;
        else if (idx == window_geom_pkg::IDX_SCROLL_START_LO)
            slot_of = window_geom_pkg::S_SCR_S_LO;
        else if (idx == window_geom_pkg::IDX_SCROLL_START_HI)
            slot_of = window_geom_pkg::S_SCR_S_HI;
        else if (idx == window_geom_pkg::IDX_SCROLL_END_LO)
            slot_of = window_geom_pkg::S_SCR_E_LO;
        else if (idx == window_geom_pkg::IDX_SCROLL_END_HI)
            slot_of = window_geom_pkg::S_SCR_E_HI;
        else if (idx == window_geom_pkg::IDX_M1_START_LO)
            slot_of = window_geom_pkg::S_M1_S_LO;
        else if (idx == window_geom_pkg::IDX_M1_START_HI)
            slot_of = window_geom_pkg::S_M1_S_HI;
        else if (idx == window_geom_pkg::IDX_M1_LINE_OFS)
            slot_of = window_geom_pkg::S_M1_OFS;
        else if (idx == window_geom_pkg::IDX_M1_WIDTH)
            slot_of = window_geom_pkg::S_M1_W;
        else if (idx == window_geom_pkg::IDX_M1_HEIGHT)
            slot_of = window_geom_pkg::S_M1_H;
        else if (idx == window_geom_pkg::IDX_M2_START_LO)
            slot_of = window_geom_pkg::S_M2_S_LO;
        else if (idx == window_geom_pkg::IDX_M2_START_HI)
            slot_of = window_geom_pkg::S_M2_S_HI;
        else if (idx == window_geom_pkg::IDX_STATUS)
            slot_of = window_geom_pkg::S_STATUS;
        else
            slot_of = window_geom_pkg::S_NONE;
    endfunction

    // Writable bits of each slot; everything else stays zero
    function automatic logic [15:0] mask_of(input int s);
        if (s == int'(window_geom_pkg::S_M1_OFS))
            mask_of = window_geom_pkg::MASK_OFS;
        else if (s == int'(window_geom_pkg::S_M1_W) || s == int'(window_geom_pkg::S_M1_H))
            mask_of = window_geom_pkg::MASK_SIZE;
        else if (s == int'(window_geom_pkg::S_SCR_S_HI) || s == int'(window_geom_pkg::S_SCR_E_HI)
                 || s == int'(window_geom_pkg::S_M1_S_HI) || s == int'(window_geom_pkg::S_M2_S_HI))
            mask_of = window_geom_pkg::MASK_ADDR_HI;
        else if (s == int'(window_geom_pkg::S_STATUS))
            mask_of = 16'h0000;
        else
            mask_of = window_geom_pkg::MASK_ADDR_LO;
    endfunction

    function automatic logic [15:0] reset_of(input int s);
        if (s == int'(window_geom_pkg::S_SCR_E_LO))
            reset_of = window_geom_pkg::RST_SCR_END_LO;
        else if (s == int'(window_geom_pkg::S_SCR_E_HI))
            reset_of = window_geom_pkg::RST_SCR_END_HI;
        else
            reset_of = window_geom_pkg::RST_ZERO;
    endfunction

    // Handshake terms for the write path
    wire        aw_take    = s_axi_awvalid && awready_r;
    wire        w_take     = s_axi_wvalid && wready_r;
    wire        do_write   = aw_have_r && w_have_r;
    wire [3:0]  wr_slot    = slot_of(aw_addr_r);
    wire        wr_mapped  = (wr_slot != window_geom_pkg::S_NONE);
    wire [15:0] lane_mask  = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
    wire        aw_have_nxt = do_write ? 1'b0 : (aw_have_r || aw_take);
    wire        w_have_nxt  = do_write ? 1'b0 : (w_have_r || w_take);
    wire        bvalid_nxt  = do_write || (bvalid_r && !s_axi_bready);

    // Handshake terms for the read path
    wire        ar_take    = s_axi_arvalid && arready_r;
    wire [3:0]  rd_slot    = slot_of(s_axi_araddr);
    wire        rd_mapped  = (rd_slot != window_geom_pkg::S_NONE);
    wire        rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);

    // Live status; the bank only reports it
    wire [15:0] status_word = {cfg_bus.busy, 4'h0, cfg_bus.disp_line};
    wire [15:0] rd_word     = (rd_slot == window_geom_pkg::S_STATUS) ? status_word :
                              rd_mapped ? regs_r[rd_slot] : 16'h0000;

    // Configuration fields handed to the sequencer
    assign cfg_bus.start_addr   = {regs_r[window_geom_pkg::S_M1_S_HI][window_geom_pkg::HI_NIB_MSB:0],
                                   regs_r[window_geom_pkg::S_M1_S_LO]};
    assign cfg_bus.line_offset  = regs_r[window_geom_pkg::S_M1_OFS][window_geom_pkg::OFS_MSB:0];
    assign cfg_bus.vdbl_en      = regs_r[window_geom_pkg::S_M1_OFS][window_geom_pkg::OFS_VDBL_BIT];
    assign cfg_bus.hdbl_en      = regs_r[window_geom_pkg::S_M1_OFS][window_geom_pkg::OFS_HDBL_BIT];
    assign cfg_bus.width_m1     = regs_r[window_geom_pkg::S_M1_W][window_geom_pkg::SIZE_MSB:0];
    assign cfg_bus.height_m1    = regs_r[window_geom_pkg::S_M1_H][window_geom_pkg::SIZE_MSB:0];
    assign cfg_bus.scroll_start = {regs_r[window_geom_pkg::S_SCR_S_HI][window_geom_pkg::HI_NIB_MSB:0],
                                   regs_r[window_geom_pkg::S_SCR_S_LO]};
    assign cfg_bus.scroll_end   = {regs_r[window_geom_pkg::S_SCR_E_HI][window_geom_pkg::HI_NIB_MSB:0],
                                   regs_r[window_geom_pkg::S_SCR_E_LO]};

    // Bus outputs straight from their flops
    assign s_axi_awready  = awready_r;
    assign s_axi_wready   = wready_r;
    assign s_axi_bvalid   = bvalid_r;
    assign s_axi_bresp    = bresp_r;
    assign s_axi_arready  = arready_r;
    assign s_axi_rvalid   = rvalid_r;
    assign s_axi_rdata    = rdata_r;
    assign s_axi_rresp    = rresp_r;
    assign second_start_r = second_r;

    // Write channel capture; address and data may come in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= 32'h00000000;
            w_strb_r  <= 4'h0;
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= window_geom_pkg::RESP_OKAY;
        end
        else
        begin
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            // Ready drops while a response is owed, so one write at a time
            awready_r <= !aw_have_nxt && !bvalid_nxt;
            wready_r  <= !w_have_nxt && !bvalid_nxt;
            bvalid_r  <= bvalid_nxt;
            if (aw_take)
                aw_addr_r <= s_axi_awaddr;
            if (w_take)
            begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write)
                bresp_r <= wr_mapped ? window_geom_pkg::RESP_OKAY : window_geom_pkg::RESP_SLVERR;
        end
    end

    // Storage; masking keeps unused bits at zero
    generate
        for (genvar s = 0; s < window_geom_pkg::NUM_SLOTS; s++)
        begin : g_slot
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    regs_r[s] <= reset_of(s);
                else if (do_write && wr_slot == 4'(s))
                    regs_r[s] <= ((regs_r[s] & ~lane_mask) | (w_data_r[15:0] & lane_mask))
                                 & mask_of(s);
            end
        end
    endgenerate

    // Second window start, registered for its own fetch logic
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            second_r <= 20'h00000;
        else
            second_r <= {regs_r[window_geom_pkg::S_M2_S_HI][window_geom_pkg::HI_NIB_MSB:0],
                         regs_r[window_geom_pkg::S_M2_S_LO]};
    end

    // Read channel; answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= window_geom_pkg::RESP_OKAY;
        end
        else
        begin
            arready_r <= !rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_take)
            begin
                rdata_r <= {16'h0000, rd_word};
                rresp_r <= rd_mapped ? window_geom_pkg::RESP_OKAY : window_geom_pkg::RESP_SLVERR;
            end
        end
    end

    window_fetch_seq u_fetch (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .cfg           (cfg_bus),
        .frame_start   (frame_start),
        .pix_req       (pix_req),
        .fetch_addr_r  (fetch_addr_r),
        .fetch_valid_r (fetch_valid_r),
        .line_last_r   (line_last_r),
        .frame_last_r  (frame_last_r)
    );
endmodule
`default_nettype wire

// *** window_geom_pkg.sv ***
// Constants for the first window geometry register bank and its fetch sequencer.
// Assumes a 16-bit register file reached over a 32-bit AXI4-Lite slave.
package window_geom_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_SCROLL_START_LO = 12'h238;
    localparam logic [11:0] IDX_SCROLL_START_HI = 12'h23a;
    localparam logic [11:0] IDX_SCROLL_END_LO   = 12'h23c;
    localparam logic [11:0] IDX_SCROLL_END_HI   = 12'h23e;
    localparam logic [11:0] IDX_M1_START_LO     = 12'h240;
    localparam logic [11:0] IDX_M1_START_HI     = 12'h242;
    localparam logic [11:0] IDX_M1_LINE_OFS     = 12'h244;
    localparam logic [11:0] IDX_M1_WIDTH        = 12'h246;
    localparam logic [11:0] IDX_M1_HEIGHT       = 12'h248;
    localparam logic [11:0] IDX_M2_START_LO     = 12'h24a;
    localparam logic [11:0] IDX_M2_START_HI     = 12'h24c;
    localparam logic [11:0] IDX_STATUS          = 12'h254;

    // Storage slots
    localparam int NUM_SLOTS = 12;
    localparam logic [3:0] S_SCR_S_LO = 4'h0;
    localparam logic [3:0] S_SCR_S_HI = 4'h1;
    localparam logic [3:0] S_SCR_E_LO = 4'h2;
    localparam logic [3:0] S_SCR_E_HI = 4'h3;
    localparam logic [3:0] S_M1_S_LO  = 4'h4;
    localparam logic [3:0] S_M1_S_HI  = 4'h5;
    localparam logic [3:0] S_M1_OFS   = 4'h6;
    localparam logic [3:0] S_M1_W     = 4'h7;
    localparam logic [3:0] S_M1_H     = 4'h8;
    localparam logic [3:0] S_M2_S_LO  = 4'h9;
    localparam logic [3:0] S_M2_S_HI  = 4'ha;
    localparam logic [3:0] S_STATUS   = 4'hb;
    localparam logic [3:0] S_NONE     = 4'hf;

    // Writable bit masks
    localparam logic [15:0] MASK_ADDR_LO = 16'hfffe;
    localparam logic [15:0] MASK_ADDR_HI = 16'h000f;
    localparam logic [15:0] MASK_OFS     = 16'h3ffe;
    localparam logic [15:0] MASK_SIZE    = 16'h03ff;

    // Reset values
    localparam logic [15:0] RST_ZERO       = 16'h0000;
    localparam logic [15:0] RST_SCR_END_LO = 16'hfffe;
    localparam logic [15:0] RST_SCR_END_HI = 16'h000f;

    // Field positions in the line offset, high address, size and status registers
    localparam int OFS_VDBL_BIT = 13;
    localparam int OFS_HDBL_BIT = 12;
    localparam int OFS_MSB      = 11;
    localparam int HI_NIB_MSB   = 3;
    localparam int SIZE_MSB     = 9;
    localparam int STAT_BUSY_BIT = 15;

    // Bytes per source pixel at 16 bpp
    localparam logic [19:0] PIX_BYTES = 20'h00002;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        FS_IDLE   = 2'b00,
        FS_ACTIVE = 2'b01,
        FS_DONE   = 2'b10
    } fetch_state_t;

endpackage

// *** window_cfg_if.sv ***
// Carrier between the register bank and the fetch sequencer.
// Assumes both ends sit on the same aclk.
`timescale 1ns/1ps
`default_nettype none
interface window_cfg_if;
    logic [19:0] start_addr;
    logic [11:0] line_offset;
    logic        hdbl_en;
    logic        vdbl_en;
    logic [9:0]  width_m1;
    logic [9:0]  height_m1;
    logic [19:0] scroll_start;
    logic [19:0] scroll_end;
    logic        busy;
    logic [10:0] disp_line;

    modport regs (output start_addr, line_offset, hdbl_en, vdbl_en, width_m1, height_m1,
                  output scroll_start, scroll_end, input busy, disp_line);
    modport engine (input start_addr, line_offset, hdbl_en, vdbl_en, width_m1, height_m1,
                    input scroll_start, scroll_end, output busy, disp_line);
endinterface
`default_nettype wire

// *** window_fetch_seq.sv ***
// Fetch address sequencer for the first window, with pixel doubling and scroll wrap.
// Assumes frame_start and pix_req are one-cycle pulses from logic on aclk.
`timescale 1ns/1ps
`default_nettype none
module window_fetch_seq (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    window_cfg_if.engine      cfg,
    input  wire logic         frame_start,
    input  wire logic         pix_req,
    output logic [19:0]       fetch_addr_r,
    output logic              fetch_valid_r,
    output logic              line_last_r,
    output logic              frame_last_r
);
    window_geom_pkg::fetch_state_t state_r;
    logic [19:0] line_base_r;
    logic [19:0] pix_addr_r;
    logic [9:0]  src_x_r;
    logic [9:0]  src_y_r;
    logic        rep_h_r;
    logic        rep_v_r;
    logic [10:0] disp_line_r;

    // Past the scroll end the running address restarts at scroll start
    function automatic logic [19:0] wrap(input logic [19:0] a);
        wrap = (a > cfg.scroll_end) ? cfg.scroll_start : a;
    endfunction

    wire         active    = (state_r == window_geom_pkg::FS_ACTIVE);
    wire         step      = active && pix_req && !frame_start; // Restart wins; no stale fetch pulse
    wire         x_end     = (src_x_r == cfg.width_m1);
    wire         y_end     = (src_y_r == cfg.height_m1);
    wire         h_done    = !cfg.hdbl_en || rep_h_r;
    wire         v_done    = !cfg.vdbl_en || rep_v_r;
    wire         line_done = h_done && x_end;
    wire         frame_done = line_done && v_done && y_end;
    wire [19:0]  next_pix  = wrap(pix_addr_r + window_geom_pkg::PIX_BYTES);
    wire [19:0]  next_line = wrap(line_base_r + {8'h00, cfg.line_offset});

    assign cfg.busy      = active;
    assign cfg.disp_line = disp_line_r;

    // Walk source pixels; repeat pixels and lines while doubling
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r       <= window_geom_pkg::FS_IDLE;
            line_base_r   <= 20'h00000;
            pix_addr_r    <= 20'h00000;
            src_x_r       <= 10'h000;
            src_y_r       <= 10'h000;
            rep_h_r       <= 1'b0;
            rep_v_r       <= 1'b0;
            disp_line_r   <= 11'h000;
            fetch_addr_r  <= 20'h00000;
            fetch_valid_r <= 1'b0;
            line_last_r   <= 1'b0;
            frame_last_r  <= 1'b0;
        end
        else
        begin
            fetch_valid_r <= step;
            line_last_r   <= step && line_done;
            frame_last_r  <= step && frame_done;
            if (frame_start)
            begin
                // A new frame restarts the walk even mid-frame
                state_r     <= window_geom_pkg::FS_ACTIVE;
                line_base_r <= cfg.start_addr;
                pix_addr_r  <= cfg.start_addr;
                src_x_r     <= 10'h000;
                src_y_r     <= 10'h000;
                rep_h_r     <= 1'b0;
                rep_v_r     <= 1'b0;
                disp_line_r <= 11'h000;
            end
            else if (step)
            begin
                fetch_addr_r <= pix_addr_r;
                if (!h_done)
                begin
                    rep_h_r <= 1'b1;
                end
                else if (!x_end)
                begin
                    rep_h_r    <= 1'b0;
                    src_x_r    <= src_x_r + 10'h001;
                    pix_addr_r <= next_pix;
                end
                else
                begin
                    rep_h_r     <= 1'b0;
                    src_x_r     <= 10'h000;
                    disp_line_r <= disp_line_r + 11'h001;
                    if (!v_done)
                    begin
                        rep_v_r    <= 1'b1;
                        pix_addr_r <= line_base_r;
                    end
                    else if (!y_end)
                    begin
                        rep_v_r     <= 1'b0;
                        src_y_r     <= src_y_r + 10'h001;
                        line_base_r <= next_line;
                        pix_addr_r  <= next_line;
                    end
                    else
                    begin
                        rep_v_r <= 1'b0;
                        state_r <= window_geom_pkg::FS_DONE;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** window_geom_regs_monitor.sv ***
// Port checker for the window geometry register bank.
// Assumes one aclk domain and a bind onto window_geom_regs.
`timescale 1ns/1ps
`default_nettype none
module window_geom_regs_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        frame_start,
    input wire logic        pix_req,
    input wire logic [19:0] fetch_addr_r,
    input wire logic        fetch_valid_r,
    input wire logic        line_last_r,
    input wire logic        frame_last_r
);
    // Single domain, so one clock and one disable for all
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response late");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_upper_half_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_fetch_has_cause: assert property (fetch_valid_r |-> $past(pix_req) && !$past(frame_start))
        else $error("fetch without request");
    a_last_is_qualified: assert property (line_last_r || frame_last_r |-> fetch_valid_r)
        else $error("last flag without fetch");
    a_frame_ends_line: assert property (frame_last_r |-> line_last_r)
        else $error("frame end not at line end");
    a_fetch_addr_even: assert property (fetch_valid_r |-> !fetch_addr_r[0])
        else $error("odd fetch address");
    a_done_refuses: assert property (frame_last_r |=> !fetch_valid_r)
        else $error("fetch after frame end");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_frame: cover property (frame_last_r);
endmodule
bind window_geom_regs window_geom_regs_monitor window_geom_regs_monitor_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .frame_start, .pix_req, .fetch_addr_r,
    .fetch_valid_r, .line_last_r, .frame_last_r);
`default_nettype wire

// *** window_geom_regs_bench.sv ***
// Self-checking bench for the window geometry register bank.
// Assumes the bound checker and byte address = 4 * register index.
`timescale 1ns/1ps
`default_nettype none
module window_geom_regs_bench;
    typedef struct packed {logic [11:0] idx; logic [15:0] wd; logic [15:0] rd; logic [1:0] rsp;} row_t;
    logic        aclk = 1'b0, aresetn = 1'b0, frame_start = 1'b0, pix_req = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd_v;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        fetch_valid_r, line_last_r, frame_last_r;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp_v;
    logic [19:0] fetch_addr_r, second_start_r;
    logic [19:0] exp_a [16];
    int          miscompares = 0, checks_done = 0;
    // Masked fields and one unmapped index: writes of all ones read back only the stored bits
    row_t rows [8] = '{'{12'h240, 16'hffff, 16'hfffe, 2'b00}, '{12'h242, 16'hffff, 16'h000f, 2'b00},
        '{12'h244, 16'hffff, 16'h3ffe, 2'b00}, '{12'h246, 16'hffff, 16'h03ff, 2'b00},
        '{12'h248, 16'hffff, 16'h03ff, 2'b00}, '{12'h24a, 16'hffff, 16'hfffe, 2'b00},
        '{12'h24c, 16'hffff, 16'h000f, 2'b00}, '{12'h250, 16'hffff, 16'h0000, 2'b10}};

    window_geom_regs window_geom_regs_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .frame_start, .pix_req, .fetch_addr_r, .fetch_valid_r, .line_last_r, .frame_last_r,
        .second_start_r);

    // 200 MHz
    always #2.5 aclk = ~aclk;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bounded wait: a hung handshake ends the run
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 60)
        begin
            miscompares++;
            complete_run();
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic wr(input logic [11:0] idx, input logic [15:0] d, input logic [3:0] st);
        int n;
        n = 0;
        s_axi_awaddr <= {idx[9:0], 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rsp_v = s_axi_bresp;
        // Idle edge, so a next call never re-raises bready in this step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] idx);
        int n;
        n = 0;
        s_axi_araddr <= {idx[9:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_v = s_axi_rdata;
        rsp_v = s_axi_rresp;
        // Idle edge, so a next call never re-raises rready in this step
        @(posedge aclk);
    endtask

    // One frame walk with pix_req held high, compared pixel by pixel
    task automatic frame(input int n, input int per);
        int w;
        frame_start <= 1'b1;
        @(posedge aclk);
        frame_start <= 1'b0;
        pix_req <= 1'b1;
        for (int k = 0; k < n; k++)
        begin
            w = 0;
            do tick(w); while (!fetch_valid_r);
            chk(32'(fetch_addr_r), 32'(exp_a[k]));
            chk(32'(line_last_r), 32'((k % per) == per - 1));
            chk(32'(frame_last_r), 32'(k == n - 1));
        end
        @(posedge aclk);
        pix_req <= 1'b0;
        chk(32'(fetch_valid_r), 32'h0);
    endtask

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i])
        begin
            wr(rows[i].idx, rows[i].wd, 4'hf);
            chk(32'(rsp_v), 32'(rows[i].rsp));
            rd(rows[i].idx);
            chk(rd_v, {16'h0000, rows[i].rd});
            chk(32'(rsp_v), 32'(rows[i].rsp));
        end
        chk(32'(second_start_r), 32'h000ffffe);
        $display("test table done");
        // Low lane only: the upper size bits must survive
        wr(12'h246, 16'h0155, 4'h1);
        rd(12'h246);
        chk(rd_v, 32'h00000355);
        $display("test strobe done");
        // 2x2 source doubled both ways: 4 lines of 4 pixels
        wr(12'h240, 16'h0100, 4'hf);
        wr(12'h242, 16'h0000, 4'hf);
        wr(12'h244, 16'h3010, 4'hf);
        wr(12'h246, 16'h0001, 4'hf);
        wr(12'h248, 16'h0001, 4'hf);
        for (int k = 0; k < 16; k++)
            exp_a[k] = 20'h00100 + 20'(k / 8) * 20'h00010 + 20'((k % 4) / 2) * 20'h00002;
        frame(16, 4);
        $display("test doubling done");
        // Scroll end at the last pixel of line 0, so line 1 wraps to scroll start
        wr(12'h23c, 16'h0102, 4'hf);
        wr(12'h23e, 16'h0000, 4'hf);
        wr(12'h238, 16'h0040, 4'hf);
        wr(12'h244, 16'h0010, 4'hf);
        exp_a[0:3] = '{20'h00100, 20'h00102, 20'h00040, 20'h00042};
        frame(4, 2);
        $display("test scroll done");
        // Restart mid-frame with requests still high: first fetch must be the new start
        frame_start <= 1'b1;
        pix_req <= 1'b1;
        @(posedge aclk);
        frame_start <= 1'b0;
        repeat (2) @(posedge aclk);
        frame(4, 2);
        $display("test restart done");
        // Second reset in mid-run
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i])
        begin
            rd(rows[i].idx);
            chk(rd_v, 32'h00000000);
        end
        rd(12'h23c);
        chk(rd_v, 32'h0000fffe);
        $display("test reset done");
        complete_run();
    end
endmodule
`default_nettype wire
